// [design/moncal_pkg.sv]
// Package with register map, reset values and shared types of the monitor calibration block.
package moncal_pkg;
    localparam logic [7:0]  ADDR_FORCE      = 8'h00;
    localparam logic [7:0]  ADDR_STATUS     = 8'h04;
    localparam logic [7:0]  ADDR_SHIFT_A    = 8'h08;
    localparam logic [7:0]  ADDR_SHIFT_B    = 8'h0c;
    localparam logic [7:0]  ADDR_GAIN_BASE  = 8'h10;
    localparam logic [7:0]  ADDR_GAIN_CRS   = 8'h20;
    localparam logic [7:0]  ADDR_OFFS_BASE  = 8'h24;
    localparam logic [7:0]  ADDR_OFFS_CRS   = 8'h34;
    localparam logic [7:0]  ADDR_RES_BASE   = 8'h5c;
    localparam logic [7:0]  ADDR_RX_RESULT  = 8'h68;
    localparam int          FINE_FORCE_POS  = 0;
    localparam int          COARSE_FORCE_POS = 1;
    localparam int          SHIFT_BIAS_POS  = 0;
    localparam int          SHIFT_TX_POS    = 3;
    localparam int          SHIFT_RX_POS    = 0;
    localparam logic [15:0] GAIN_RESET      = 16'h8000;
    localparam logic [15:0] OFFS_RESET      = 16'h0000;
    localparam logic [2:0]  SHIFT_RESET     = 3'h0;
    localparam logic [1:0]  FORCE_RESET     = 2'h0;
    localparam logic [15:0] FULL_SCALE      = 16'hfff8;
    localparam logic [15:0] FINE_MAX_BASE   = 16'hfff8;
    localparam logic [15:0] COARSE_MIN_BASE = 16'hf000;
    localparam int          GAIN_FRAC_BITS  = 15;
    localparam int          OFFS_SCALE_BITS = 2;
    localparam logic [1:0]  CH_VCC          = 2'h0;
    localparam logic [1:0]  CH_RX           = 2'h3;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    typedef struct packed {
        logic [15:0] gain;
        logic [15:0] offset;
        logic [2:0]  shift;
    } cal_s;

    typedef enum logic {ST_ISSUE, ST_WAIT} seq_e;
endpackage

// [design/moncal_top.sv]
// Monitor calibration block: conversion sequencer, calibration datapath and register slave.
`timescale 1ns/1ps
module moncal_top #(
    parameter int ADC_BITS = 13
) (
    input  wire logic                CLK,
    input  wire logic                RESET_N,
    input  wire logic                CE,
    output logic                     ADC_START,
    output logic [1:0]               ADC_CHAN,
    output logic                     ADC_COARSE,
    input  wire logic                ADC_DONE,
    input  wire logic [ADC_BITS-1:0] ADC_DATA,
    input  wire logic [7:0]          S_AXI_AWADDR,
    input  wire logic                S_AXI_AWVALID,
    output logic                     S_AXI_AWREADY,
    input  wire logic [31:0]         S_AXI_WDATA,
    input  wire logic [3:0]          S_AXI_WSTRB,
    input  wire logic                S_AXI_WVALID,
    output logic                     S_AXI_WREADY,
    output logic [1:0]               S_AXI_BRESP,
    output logic                     S_AXI_BVALID,
    input  wire logic                S_AXI_BREADY,
    input  wire logic [7:0]          S_AXI_ARADDR,
    input  wire logic                S_AXI_ARVALID,
    output logic                     S_AXI_ARREADY,
    output logic [31:0]              S_AXI_RDATA,
    output logic [1:0]               S_AXI_RRESP,
    output logic                     S_AXI_RVALID,
    input  wire logic                S_AXI_RREADY
);
    logic [15:0]          gain [5];
    logic [15:0]          offs [5];
    logic [5:0]           shift_a;
    logic [2:0]           shift_b;
    logic [1:0]           force_bits;
    logic [15:0]          result [4];
    logic                 range_status;
    moncal_pkg::seq_e     state;
    moncal_pkg::seq_e     next_state;
    logic [1:0]           chan;
    logic [1:0]           next_chan;
    logic                 coarse;
    logic                 next_coarse;
    logic                 store;
    logic                 next_range_status;
    moncal_pkg::cal_s     cal_set;
    logic [15:0]          cal_val;
    logic [15:0]          thr;
    logic                 go_coarse;
    logic                 dual_on;
    logic                 force_coarse;

    // Gain is a fixed-point factor with unity at bit 15; offset counts in units of four LSBs.
    function automatic logic [15:0] calibrate(input logic [ADC_BITS-1:0] raw,
                                              input moncal_pkg::cal_s cs);
        logic [15:0] raw16;
        logic [31:0] prod;
        logic [16:0] gained;
        logic signed [18:0] sum;
        logic [15:0] sat;
        raw16 = {raw, {(16 - ADC_BITS){1'b0}}};
        prod = raw16 * cs.gain;
        gained = prod[31:moncal_pkg::GAIN_FRAC_BITS];
        sum = $signed({2'b00, gained}) + $signed({{1{cs.offset[15]}}, cs.offset, 2'b00});
        if (sum < 0)
            sat = 16'h0000;
        else if (sum > $signed(19'h0ffff))
            sat = 16'hffff;
        else
            sat = sum[15:0];
        return sat >> cs.shift;
    endfunction

    function automatic logic [2:0] chan_shift(input logic [1:0] ch, input logic [5:0] sa,
                                              input logic [2:0] sb);
        unique case (ch)
            2'h1:    return sa[moncal_pkg::SHIFT_BIAS_POS +: 3];
            2'h2:    return sa[moncal_pkg::SHIFT_TX_POS +: 3];
            2'h3:    return sb[moncal_pkg::SHIFT_RX_POS +: 3];
            default: return moncal_pkg::SHIFT_RESET;
        endcase
    endfunction

    // Coarse set lives at index 4 and never shifts.
    always_comb
    begin
        if (chan == moncal_pkg::CH_RX && coarse)
        begin
            cal_set.gain   = gain[4];
            cal_set.offset = offs[4];
            cal_set.shift  = 3'h0;
        end
        else
        begin
            cal_set.gain   = gain[chan];
            cal_set.offset = offs[chan];
            cal_set.shift  = chan_shift(chan, shift_a, shift_b);
        end
    end

    assign cal_val      = calibrate(ADC_DATA, cal_set);
    assign dual_on      = force_bits == 2'b00;
    assign force_coarse = force_bits == 2'b10;
    // Hysteresis: a coarse previous slice keeps coarse down to the lower threshold.
    assign thr = range_status ? (moncal_pkg::COARSE_MIN_BASE >> cal_set.shift)
                              : (moncal_pkg::FINE_MAX_BASE >> cal_set.shift);
    assign go_coarse = dual_on && chan == moncal_pkg::CH_RX && !coarse && cal_val >= thr;

    always_comb
    begin
        next_state        = state;
        next_chan         = chan;
        next_coarse       = coarse;
        next_range_status = range_status;
        store             = 1'b0;
        unique case (state)
            moncal_pkg::ST_ISSUE:
                next_state = moncal_pkg::ST_WAIT;
            moncal_pkg::ST_WAIT:
                if (ADC_DONE)
                begin
                    next_state = moncal_pkg::ST_ISSUE;
                    if (go_coarse)
                        next_coarse = 1'b1;
                    else
                    begin
                        store     = 1'b1;
                        next_chan = chan + 2'h1;
                        next_coarse = (chan + 2'h1 == moncal_pkg::CH_RX) && force_coarse;
                        if (chan == moncal_pkg::CH_RX)
                            next_range_status = coarse;
                    end
                end
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            state        <= moncal_pkg::ST_ISSUE;
            chan         <= moncal_pkg::CH_VCC;
            coarse       <= 1'b0;
            range_status <= 1'b0;
            for (int i = 0; i < 4; i++)
                result[i] <= 16'h0000;
        end
        else if (CE)
        begin
            state        <= next_state;
            chan         <= next_chan;
            coarse       <= next_coarse;
            range_status <= next_range_status;
            if (store)
                result[chan] <= cal_val;
        end
    end

    assign ADC_START  = CE && state == moncal_pkg::ST_ISSUE;
    assign ADC_CHAN   = chan;
    assign ADC_COARSE = coarse;

    // Register slave: address and data are taken in any order, one write and one read at a time.
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_write;
    logic        wr_hit;
    logic [31:0] rd_word;
    logic        rd_hit;

    assign S_AXI_AWREADY = CE && !aw_held && !S_AXI_BVALID;
    assign S_AXI_WREADY  = CE && !w_held && !S_AXI_BVALID;
    assign S_AXI_ARREADY = CE && !S_AXI_RVALID;
    assign do_write      = CE && aw_held && w_held && !S_AXI_BVALID;

    always_comb
    begin
        wr_hit = (aw_addr <= moncal_pkg::ADDR_OFFS_CRS) && (aw_addr[1:0] == 2'b00)
                 && (aw_addr != moncal_pkg::ADDR_STATUS);
    end

    always_comb
    begin
        rd_word = 32'h0;
        rd_hit  = 1'b1;
        if (S_AXI_ARADDR[1:0] != 2'b00)
            rd_hit = 1'b0;
        else if (S_AXI_ARADDR == moncal_pkg::ADDR_FORCE)
            rd_word[1:0] = force_bits;
        else if (S_AXI_ARADDR == moncal_pkg::ADDR_STATUS)
            rd_word[0] = range_status;
        else if (S_AXI_ARADDR == moncal_pkg::ADDR_SHIFT_A)
            rd_word[5:0] = shift_a;
        else if (S_AXI_ARADDR == moncal_pkg::ADDR_SHIFT_B)
            rd_word[2:0] = shift_b;
        else if (S_AXI_ARADDR >= moncal_pkg::ADDR_GAIN_BASE &&
                 S_AXI_ARADDR <= moncal_pkg::ADDR_GAIN_CRS)
            rd_word[15:0] = gain[3'(S_AXI_ARADDR[7:2] - moncal_pkg::ADDR_GAIN_BASE[7:2])];
        else if (S_AXI_ARADDR >= moncal_pkg::ADDR_OFFS_BASE &&
                 S_AXI_ARADDR <= moncal_pkg::ADDR_OFFS_CRS)
            rd_word[15:0] = offs[3'(S_AXI_ARADDR[7:2] - moncal_pkg::ADDR_OFFS_BASE[7:2])];
        else if (S_AXI_ARADDR >= moncal_pkg::ADDR_RES_BASE &&
                 S_AXI_ARADDR <= moncal_pkg::ADDR_RX_RESULT)
            rd_word[15:0] = result[2'(S_AXI_ARADDR[7:2] - moncal_pkg::ADDR_RES_BASE[7:2])];
        else
            rd_hit = 1'b0;
    end

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h0;
            w_strb       <= 4'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= moncal_pkg::RESP_OKAY;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RRESP  <= moncal_pkg::RESP_OKAY;
            S_AXI_RDATA  <= 32'h0;
            force_bits   <= moncal_pkg::FORCE_RESET;
            shift_a      <= {2{moncal_pkg::SHIFT_RESET}};
            shift_b      <= moncal_pkg::SHIFT_RESET;
            for (int i = 0; i < 5; i++)
            begin
                gain[i] <= moncal_pkg::GAIN_RESET;
                offs[i] <= moncal_pkg::OFFS_RESET;
            end
        end
        else if (CE)
        begin
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
            end
            if (do_write)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= wr_hit ? moncal_pkg::RESP_OKAY : moncal_pkg::RESP_SLVERR;
                if (wr_hit && w_strb[0])
                begin
                    if (aw_addr == moncal_pkg::ADDR_FORCE)
                        force_bits <= w_data[1:0];
                    else if (aw_addr == moncal_pkg::ADDR_SHIFT_A)
                        shift_a <= w_data[5:0];
                    else if (aw_addr == moncal_pkg::ADDR_SHIFT_B)
                        shift_b <= w_data[2:0];
                end
                if (wr_hit && aw_addr >= moncal_pkg::ADDR_GAIN_BASE)
                begin
                    // Byte lanes 0 and 1 carry the two halves of a 16-bit setting.
                    for (int b = 0; b < 2; b++)
                        if (w_strb[b])
                        begin
                            if (aw_addr <= moncal_pkg::ADDR_GAIN_CRS)
                                gain[3'(aw_addr[7:2] - moncal_pkg::ADDR_GAIN_BASE[7:2])][b*8 +: 8]
                                    <= w_data[b*8 +: 8];
                            else
                                offs[3'(aw_addr[7:2] - moncal_pkg::ADDR_OFFS_BASE[7:2])][b*8 +: 8]
                                    <= w_data[b*8 +: 8];
                        end
                end
            end
            if (S_AXI_BVALID && S_AXI_BREADY)
                S_AXI_BVALID <= 1'b0;
            if (S_AXI_ARVALID && S_AXI_ARREADY)
            begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA  <= rd_word;
                S_AXI_RRESP  <= rd_hit ? moncal_pkg::RESP_OKAY : moncal_pkg::RESP_SLVERR;
            end
            else if (S_AXI_RVALID && S_AXI_RREADY)
                S_AXI_RVALID <= 1'b0;
        end
    end

    sequence s_rx_fine_done;
        CE && state == moncal_pkg::ST_WAIT && ADC_DONE && chan == moncal_pkg::CH_RX && !coarse;
    endsequence
    sequence s_coarse_issue;
        ADC_COARSE && ADC_CHAN == moncal_pkg::CH_RX && (ADC_START || !CE);
    endsequence
    property p_coarse_follow;
        @(posedge CLK) disable iff (!RESET_N)
        (s_rx_fine_done and go_coarse) |=> s_coarse_issue;
    endproperty
    a_coarse_follow: assert property (p_coarse_follow) else $error("coarse not issued");

    property p_rx_store;
        @(posedge CLK) disable iff (!RESET_N)
        (store && CE && chan == moncal_pkg::CH_RX) |=> result[3] == $past(cal_val);
    endproperty
    a_rx_store: assert property (p_rx_store) else $error("rx result not stored");

    property p_status;
        @(posedge CLK) disable iff (!RESET_N)
        (store && CE && chan == moncal_pkg::CH_RX) |=> range_status == $past(coarse);
    endproperty
    a_status: assert property (p_status) else $error("range status wrong");

    property p_force_fine;
        @(posedge CLK) disable iff (!RESET_N)
        (force_bits == 2'b01 && ADC_START) |-> !ADC_COARSE;
    endproperty
    a_force_fine: assert property (p_force_fine) else $error("coarse while disabled");

    property p_force_coarse;
        @(posedge CLK) disable iff (!RESET_N)
        (force_bits == 2'b10 && $stable(force_bits) && ADC_START && ADC_CHAN == 2'h3)
            |-> ADC_COARSE;
    endproperty
    a_force_coarse: assert property (p_force_coarse) else $error("coarse not forced");

    property p_shift_bound;
        @(posedge CLK) disable iff (!RESET_N)
        (state == moncal_pkg::ST_WAIT) |-> cal_val <= (16'hffff >> cal_set.shift);
    endproperty
    a_shift_bound: assert property (p_shift_bound) else $error("shift not applied");

    property p_null_zero;
        @(posedge CLK) disable iff (!RESET_N)
        (ADC_DATA == '0 && cal_set.offset == 16'h0000) |-> cal_val == 16'h0000;
    endproperty
    a_null_zero: assert property (p_null_zero) else $error("null not zero");

    property p_round_robin;
        @(posedge CLK) disable iff (!RESET_N)
        (store && CE) |=> chan == $past(chan) + 2'h1 && state == moncal_pkg::ST_ISSUE;
    endproperty
    a_round_robin: assert property (p_round_robin) else $error("channel order broken");
endmodule // moncal_top

// [test/tb_top.sv]
// Self-checking bench for the monitor calibration block.
`timescale 1ns/1ps
module tb_top;
    logic        clk, reset_n, adc_done, awvalid, wvalid, bready, arvalid, rready;
    logic        adc_start, adc_coarse, awready, wready, bvalid, arready, rvalid;
    logic [1:0]  adc_chan, bresp, rresp;
    logic [12:0] adc_data, raw_crs;
    logic [12:0] raw [4];
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [33:0] rq [$];
    logic [1:0]  bq [$];
    logic [15:0] g [4];
    logic [15:0] o [4];
    logic [2:0]  s [4];
    logic [15:0] gs, m1, m2;
    logic [1:0]  frc [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h3, 2'h1};
    logic [12:0] fr [8] = '{13'h1000, 13'h1fff, 13'h1e00, 13'h1dff, 13'h1f00,
                             13'h1000, 13'h1fff, 13'h1fff};
    logic        crs [8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    int          n_mismatch, cmp_count, rounds;

    moncal_top u_dut (
        .CLK(clk), .RESET_N(reset_n), .CE(1'b1), .ADC_START(adc_start),
        .ADC_CHAN(adc_chan), .ADC_COARSE(adc_coarse), .ADC_DONE(adc_done),
        .ADC_DATA(adc_data), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
    );

    function automatic logic [15:0] cal(input logic [12:0] r, input logic [15:0] gn,
                                        input logic [15:0] of, input logic [2:0] sh);
        longint v;
        v = ((longint'({r, 3'h0}) * longint'(gn)) >>> 15) + longint'($signed(of)) * 4;
        if (v < 0) v = 0;
        if (v > 65535) v = 65535;
        return 16'(v) >> sh;
    endfunction

    task automatic report(input logic [33:0] got, input logic [33:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_rd(input logic [33:0] got, input logic [33:0] exp);
        report(got, exp);
    endtask
    task automatic cmp_wr(input logic [1:0] got, input logic [1:0] exp);
        report({32'h0, got}, {32'h0, exp});
    endtask
    task automatic cmp_ch(input logic [1:0] got, input logic [1:0] exp);
        report({32'h0, got}, {32'h0, exp});
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Every wait is bounded so a hung handshake still reaches the verdict.
    task automatic tick(inout int t);
        t++;
        if (t > 3000)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t wait count %h limit %h", $time, t, 3000);
            close_out();
        end
    endtask

    task automatic wait_rounds(input int n);
        int t;
        t = 0;
        rounds = 0;
        while (rounds < n)
        begin
            @(negedge clk);
            tick(t);
        end
    endtask

    // Ready is looked at mid-cycle; it cannot change before the next rising edge.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int   t;
        logic ap, wp, ah, wh;
        t = 0;
        ap = 1'b1;
        wp = 1'b1;
        bq.push_back(er);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (ap || wp)
        begin
            @(negedge clk);
            tick(t);
            ah = ap && awready === 1'b1;
            wh = wp && wready === 1'b1;
            @(posedge clk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            ap = ap && !ah;
            wp = wp && !wh;
        end
        do
        begin
            @(negedge clk);
            tick(t);
        end while (bvalid !== 1'b1);
        @(posedge clk);
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [33:0] exp);
        int t;
        t = 0;
        rq.push_back(exp);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(negedge clk);
            tick(t);
        end while (arready !== 1'b1);
        @(posedge clk);
        arvalid <= 1'b0;
        do
        begin
            @(negedge clk);
            tick(t);
        end while (rvalid !== 1'b1);
        @(posedge clk);
        rready <= 1'b0;
    endtask

    task automatic rd16(input logic [7:0] a, input logic [15:0] v);
        axi_rd(a, {moncal_pkg::RESP_OKAY, 16'h0, v});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axi_wr(a, d, moncal_pkg::RESP_OKAY);
    endtask

    always @(negedge clk)
    begin
        if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0)
            cmp_rd({rresp, rdata}, rq.pop_front());
        if (bvalid === 1'b1 && bready === 1'b1 && bq.size() > 0)
            cmp_wr(bresp, bq.pop_front());
    end

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Converter stand-in: random latency, data line inverted once released.
    initial
    begin
        logic [1:0] ch, exp_ch;
        logic       cr;
        int         lat;
        exp_ch = 2'h0;
        wait (reset_n === 1'b1);
        forever
        begin
            @(negedge clk);
            if (adc_start === 1'b1)
            begin
                ch = adc_chan;
                cr = adc_coarse;
                cmp_ch(ch, cr ? 2'h3 : exp_ch);
                if (!cr || exp_ch == 2'h3) exp_ch = exp_ch + 2'h1;
                lat = $urandom_range(4, 1);
                repeat (lat) @(posedge clk);
                adc_done <= 1'b1;
                adc_data <= cr ? raw_crs : raw[ch];
                @(posedge clk);
                adc_done <= 1'b0;
                adc_data <= ~adc_data;
                if (ch == 2'h0) rounds++;
            end
        end
    end

    initial
    begin
        reset_n = 1'b0;
        {adc_done, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {adc_data, raw_crs, awaddr, araddr, wdata} = '0;
        for (int c = 0; c < 4; c++) raw[c] = 13'h0;
        void'($urandom(4684));
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        rd16(moncal_pkg::ADDR_FORCE, {14'h0, moncal_pkg::FORCE_RESET});
        rd16(moncal_pkg::ADDR_SHIFT_A, 16'h0);
        rd16(moncal_pkg::ADDR_SHIFT_B, 16'h0);
        for (int c = 0; c < 4; c++)
        begin
            rd16(moncal_pkg::ADDR_GAIN_BASE + 8'(4 * c), moncal_pkg::GAIN_RESET);
            rd16(moncal_pkg::ADDR_OFFS_BASE + 8'(4 * c), moncal_pkg::OFFS_RESET);
        end
        raw[0] <= 13'h1fff;
        wait_rounds(3);
        rd16(moncal_pkg::ADDR_RES_BASE, moncal_pkg::FULL_SCALE);
        rd16(moncal_pkg::ADDR_RES_BASE + 8'h4, 16'h0);
        wr(moncal_pkg::ADDR_FORCE, 32'h1);
        for (int k = 0; k < 3; k++)
        begin
            for (int c = 0; c < 4; c++)
            begin
                g[c] = 16'($urandom_range(65535, 16384));
                o[c] = 16'($urandom_range(255, 0)) - 16'h0080;
                s[c] = (c == 0) ? 3'h0 : 3'($urandom_range(7, 0));
                raw[c] <= 13'($urandom);
                if (k == 0 && c == 2) g[c] = 16'hffff;
                if (k == 0 && c == 2) raw[c] <= 13'h1fff;
                wr(moncal_pkg::ADDR_GAIN_BASE + 8'(4 * c), {16'h0, g[c]});
                wr(moncal_pkg::ADDR_OFFS_BASE + 8'(4 * c), {16'h0, o[c]});
            end
            wr(moncal_pkg::ADDR_SHIFT_A, {26'h0, s[2], s[1]});
            wr(moncal_pkg::ADDR_SHIFT_B, {29'h0, s[3]});
            wait_rounds(3);
            for (int c = 0; c < 4; c++)
                rd16(moncal_pkg::ADDR_RES_BASE + 8'(4 * c), cal(raw[c], g[c], o[c], s[c]));
        end
        raw_crs <= 13'($urandom);
        wr(moncal_pkg::ADDR_GAIN_BASE + 8'hc, 32'h8000);
        wr(moncal_pkg::ADDR_OFFS_BASE + 8'hc, 32'h0);
        wr(moncal_pkg::ADDR_GAIN_CRS, 32'h6000);
        wr(moncal_pkg::ADDR_OFFS_CRS, 32'h0010);
        wr(moncal_pkg::ADDR_SHIFT_B, 32'h2);
        for (int i = 0; i < 8; i++)
        begin
            wr(moncal_pkg::ADDR_FORCE, {30'h0, frc[i]});
            raw[3] <= fr[i];
            wait_rounds(3);
            rd16(moncal_pkg::ADDR_STATUS, {15'h0, crs[i]});
            rd16(moncal_pkg::ADDR_RX_RESULT, crs[i] ? cal(raw_crs, 16'h6000, 16'h0010, 3'h0)
                                                   : cal(fr[i], 16'h8000, 16'h0, 3'h2));
        end
        // Host-side calibration of the bias channel; the chosen targets put the gain at A000h.
        wr(moncal_pkg::ADDR_SHIFT_A, 32'h0);
        wr(moncal_pkg::ADDR_OFFS_BASE + 8'h4, 32'h0);
        gs = 16'h0;
        for (int n = 15; n >= 0; n--)
        begin
            gs = gs | (16'h1 << n);
            wr(moncal_pkg::ADDR_GAIN_BASE + 8'h4, {16'h0, gs});
            raw[1] <= 13'h1600;
            wait_rounds(2);
            m2 = cal(13'h1600, gs, 16'h0, 3'h0);
            rd16(moncal_pkg::ADDR_RES_BASE + 8'h4, m2);
            raw[1] <= 13'h0100;
            wait_rounds(2);
            m1 = cal(13'h0100, gs, 16'h0, 3'h0);
            rd16(moncal_pkg::ADDR_RES_BASE + 8'h4, m1);
            if (m2 >= 16'hfff0 || m2 - m1 > 16'hd200)
                gs = gs & ~(16'h1 << n);
        end
        wr(moncal_pkg::ADDR_GAIN_BASE + 8'h4, {16'h0, gs});
        rd16(moncal_pkg::ADDR_GAIN_BASE + 8'h4, 16'ha000);
        wait_rounds(2);
        rd16(moncal_pkg::ADDR_RES_BASE + 8'h4, 16'h0a00);
        wr(moncal_pkg::ADDR_OFFS_BASE + 8'h4, {16'h0, 16'h0 - (16'h0a00 >> 2)});
        wait_rounds(2);
        rd16(moncal_pkg::ADDR_RES_BASE + 8'h4, 16'h0);
        raw[1] <= 13'h1600;
        wait_rounds(2);
        rd16(moncal_pkg::ADDR_RES_BASE + 8'h4, 16'hd200);
        axi_rd(8'hf0, {moncal_pkg::RESP_SLVERR, 32'h0});
        axi_rd(8'h11, {moncal_pkg::RESP_SLVERR, 32'h0});
        axi_wr(moncal_pkg::ADDR_RX_RESULT, 32'h0, moncal_pkg::RESP_SLVERR);
        axi_wr(moncal_pkg::ADDR_STATUS, 32'h1, moncal_pkg::RESP_SLVERR);
        axi_wr(8'hf0, 32'h1, moncal_pkg::RESP_SLVERR);
        rd16(moncal_pkg::ADDR_RX_RESULT, 16'h3ffe);
        close_out();
    end
endmodule // tb_top
